// [design/asfe_pkg.sv]
package asfe_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  ASFE_IDX_CTRL      = 8'h00;
    localparam logic [7:0]  ASFE_IDX_IRQ_STAT  = 8'h02;
    localparam logic [7:0]  ASFE_IDX_IRQ_MASK  = 8'h03;
    localparam logic [7:0]  ASFE_IDX_OP_STAT   = 8'h04;
    localparam logic [7:0]  ASFE_IDX_CTL_STAT  = 8'h05;
    localparam int          ASFE_ADDR_W        = 8;

    // control register fields
    localparam int          ASFE_CTRL_CMD_LSB  = 0;
    localparam int          ASFE_CTRL_CMD_W    = 3;
    localparam int          ASFE_CTRL_IFEED    = 3;
    localparam int          ASFE_CTRL_STOP     = 4;
    localparam int          ASFE_CTRL_LINEAR   = 8;
    localparam logic        ASFE_LINEAR_RST    = 1'b1;

    // commands in the control register command field
    localparam logic [2:0]  ASFE_CMD_NONE      = 3'h0;
    localparam logic [2:0]  ASFE_CMD_ABS       = 3'h1;
    localparam logic [2:0]  ASFE_CMD_REL       = 3'h2;
    localparam logic [2:0]  ASFE_CMD_SPEED     = 3'h3;
    localparam logic [2:0]  ASFE_CMD_MEMORY    = 3'h4;
    localparam logic [2:0]  ASFE_CMD_SYN_TRQ   = 3'h5;
    localparam logic [2:0]  ASFE_CMD_SYN_VEL   = 3'h6;
    localparam logic [2:0]  ASFE_CMD_SYN_POS   = 3'h7;

    // operation-status bit positions
    localparam int          ASFE_OP_ABS        = 4;
    localparam int          ASFE_OP_REL        = 5;
    localparam int          ASFE_OP_SPEED      = 6;
    localparam int          ASFE_OP_IF_WAIT    = 7;
    localparam int          ASFE_OP_IF_POS     = 8;
    localparam int          ASFE_OP_MEMORY     = 11;
    localparam int          ASFE_OP_SYN_TRQ    = 13;
    localparam int          ASFE_OP_SYN_VEL    = 14;
    localparam int          ASFE_OP_SYN_POS    = 15;

    // control-status bit positions; events occupy bits 2..7
    localparam int          ASFE_CS_ORG_DEF    = 0;
    localparam int          ASFE_CS_AT_ORG     = 1;
    localparam int          ASFE_CS_EVT_LSB    = 2;
    localparam int          ASFE_EVT_N         = 6;

    // event order in the interrupt status register
    localparam int          ASFE_EV_LATCH      = 0;
    localparam int          ASFE_EV_ORG_LATCH  = 1;
    localparam int          ASFE_EV_CMD_OVF    = 2;
    localparam int          ASFE_EV_CMD_UNF    = 3;
    localparam int          ASFE_EV_FB_OVF     = 4;
    localparam int          ASFE_EV_FB_UNF     = 5;

    // axis command source selection
    localparam logic [1:0]  ASFE_SRC_NONE      = 2'h0;
    localparam logic [1:0]  ASFE_SRC_TRQ       = 2'h1;
    localparam logic [1:0]  ASFE_SRC_VEL       = 2'h2;
    localparam logic [1:0]  ASFE_SRC_POS       = 2'h3;

    typedef struct packed {
        logic move_done;
        logic origin_defined;
        logic in_position;
        logic latch_done;
        logic origin_latch_done;
    } asfe_core_t;

    typedef struct packed {
        logic [31:0] torque;
        logic [31:0] speed;
        logic [31:0] position;
    } asfe_cyc_buf_t;

    typedef enum logic [8:0] {
        ASFE_ST_IDLE    = 9'b000000001,
        ASFE_ST_ABS     = 9'b000000010,
        ASFE_ST_REL     = 9'b000000100,
        ASFE_ST_SPEED   = 9'b000001000,
        ASFE_ST_IF_POS  = 9'b000010000,
        ASFE_ST_MEMORY  = 9'b000100000,
        ASFE_ST_SYN_TRQ = 9'b001000000,
        ASFE_ST_SYN_VEL = 9'b010000000,
        ASFE_ST_SYN_POS = 9'b100000000
    } asfe_state_t;

endpackage

// [design/asfe_axis_status.sv]
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module asfe_axis_status
    import asfe_pkg::*;
#(
    parameter int POS_W  = 32,
    parameter int STEP_W = 16
) (
    // apb slave
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ASFE_ADDR_W+1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // interrupt
    output logic                          irq,
    // motion core, same clock
    input  wire asfe_core_t               core,
    input  wire logic signed [STEP_W-1:0] cmd_step,
    input  wire logic signed [STEP_W-1:0] fb_step,
    // cyclic command buffer
    input  wire asfe_cyc_buf_t            cyc_buf,
    // interrupt input pin
    input  wire logic                     int_pin,
    // axis command out
    output logic      [1:0]               axis_src,
    output logic      [31:0]              axis_cmd
);

    asfe_state_t                state;
    asfe_state_t                next_state;
    logic                       wait_int;
    logic                       linear;
    logic [ASFE_EVT_N-1:0]      evt_stat;
    logic [ASFE_EVT_N-1:0]      evt_mask;
    logic [ASFE_EVT_N-1:0]      evt_set;
    logic [2:0]                 int_sync;
    logic                       int_lvl;
    logic                       int_rise;
    logic [15:0]                op_stat;
    logic [15:0]                ctl_stat;
    logic                       wr_en;
    logic                       rd_en;
    logic [ASFE_ADDR_W-1:0]     idx;
    logic [2:0]                 wr_cmd;
    logic                       wr_stop;
    logic        [1:0]          pos_ovf;
    logic        [1:0]          pos_unf;

    function automatic logic hit(input logic [ASFE_ADDR_W-1:0] a,
                                 input logic [ASFE_ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    assign idx     = paddr[ASFE_ADDR_W+1:2];
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign wr_cmd  = (wr_en && hit(idx, ASFE_IDX_CTRL)) ?
                     pwdata[ASFE_CTRL_CMD_LSB +: ASFE_CTRL_CMD_W] :
                     ASFE_CMD_NONE;
    assign wr_stop = wr_en && hit(idx, ASFE_IDX_CTRL) &&
                     pwdata[ASFE_CTRL_STOP];

    // interrupt input: three flops, a change counts when the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_sync <= 3'h0;
        end else begin
            int_sync <= {int_sync[1:0], int_pin};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_lvl <= 1'b0;
        end else if (int_sync[1] == int_sync[2]) begin
            int_lvl <= int_sync[2];
        end
    end

    assign int_rise = (int_sync[1] == int_sync[2]) && int_sync[2] && !int_lvl;

    // operating mode state machine
    always_comb begin
        next_state = state;
        case (state)
            ASFE_ST_IDLE: begin
                case (wr_cmd)
                    ASFE_CMD_ABS:     next_state = ASFE_ST_ABS;
                    ASFE_CMD_REL:     next_state = ASFE_ST_REL;
                    ASFE_CMD_SPEED:   next_state = ASFE_ST_SPEED;
                    ASFE_CMD_MEMORY:  next_state = ASFE_ST_MEMORY;
                    ASFE_CMD_SYN_TRQ: next_state = ASFE_ST_SYN_TRQ;
                    ASFE_CMD_SYN_VEL: next_state = ASFE_ST_SYN_VEL;
                    ASFE_CMD_SYN_POS: next_state = ASFE_ST_SYN_POS;
                    default:          next_state = ASFE_ST_IDLE;
                endcase
            end
            ASFE_ST_ABS, ASFE_ST_REL: begin
                if (wait_int && int_rise) begin
                    next_state = ASFE_ST_IF_POS;
                end else if (!wait_int && core.move_done) begin
                    next_state = ASFE_ST_IDLE;
                end
            end
            ASFE_ST_SPEED: begin
                // speed control runs until stopped or, with interrupt feeding, the interrupt arrives
                if (wait_int && int_rise) begin
                    next_state = ASFE_ST_IF_POS;
                end
            end
            ASFE_ST_IF_POS, ASFE_ST_MEMORY: begin
                if (core.move_done) begin
                    next_state = ASFE_ST_IDLE;
                end
            end
            ASFE_ST_SYN_TRQ, ASFE_ST_SYN_VEL, ASFE_ST_SYN_POS: begin
                next_state = state;
            end
            default: next_state = ASFE_ST_IDLE;
        endcase
        // stop from software ends any mode; it wins over a new command
        if (wr_stop) begin
            next_state = ASFE_ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ASFE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // interrupt feeding option, latched with the starting command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_int <= 1'b0;
        end else if (state == ASFE_ST_IDLE && next_state != ASFE_ST_IDLE) begin
            wait_int <= pwdata[ASFE_CTRL_IFEED] &&
                        (wr_cmd == ASFE_CMD_ABS || wr_cmd == ASFE_CMD_REL ||
                         wr_cmd == ASFE_CMD_SPEED);
        end else if (next_state == ASFE_ST_IF_POS ||
                     next_state == ASFE_ST_IDLE) begin
            wait_int <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            linear <= ASFE_LINEAR_RST;
        end else if (wr_en && hit(idx, ASFE_IDX_CTRL)) begin
            linear <= pwdata[ASFE_CTRL_LINEAR];
        end
    end

    // command and feedback present positions with range checks
    for (genvar g = 0; g < 2; g++) begin : g_pos
        logic signed [STEP_W-1:0] step;
        logic signed [POS_W:0]    sum;
        logic signed [POS_W-1:0]  pos;

        assign step = (g == 0) ? cmd_step : fb_step;
        assign sum  = {pos[POS_W-1], pos} +
                      {{(POS_W+1-STEP_W){step[STEP_W-1]}}, step};
        // the two top bits of the widened sum disagree only on wrap
        assign pos_ovf[g] = linear && !sum[POS_W] && sum[POS_W-1];
        assign pos_unf[g] = linear && sum[POS_W] && !sum[POS_W-1];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pos <= '0;
            end else begin
                pos <= sum[POS_W-1:0];
            end
        end
    end

    always_comb begin
        evt_set                    = '0;
        evt_set[ASFE_EV_LATCH]     = core.latch_done;
        evt_set[ASFE_EV_ORG_LATCH] = core.origin_latch_done;
        evt_set[ASFE_EV_CMD_OVF]   = pos_ovf[0];
        evt_set[ASFE_EV_CMD_UNF]   = pos_unf[0];
        evt_set[ASFE_EV_FB_OVF]    = pos_ovf[1];
        evt_set[ASFE_EV_FB_UNF]    = pos_unf[1];
    end

    // sticky events; a set in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat <= '0;
        end else if (wr_en && hit(idx, ASFE_IDX_IRQ_STAT)) begin
            evt_stat <= (evt_stat & ~pwdata[ASFE_EVT_N-1:0]) | evt_set;
        end else begin
            evt_stat <= evt_stat | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask <= '0;
        end else if (wr_en && hit(idx, ASFE_IDX_IRQ_MASK)) begin
            evt_mask <= pwdata[ASFE_EVT_N-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_stat & evt_mask);
        end
    end

    // status words, rebuilt from live state
    always_comb begin
        op_stat                  = 16'h0000;
        op_stat[ASFE_OP_ABS]     = state == ASFE_ST_ABS;
        op_stat[ASFE_OP_REL]     = state == ASFE_ST_REL;
        op_stat[ASFE_OP_SPEED]   = state == ASFE_ST_SPEED;
        op_stat[ASFE_OP_IF_WAIT] = wait_int;
        op_stat[ASFE_OP_IF_POS]  = state == ASFE_ST_IF_POS;
        op_stat[ASFE_OP_MEMORY]  = state == ASFE_ST_MEMORY;
        op_stat[ASFE_OP_SYN_TRQ] = state == ASFE_ST_SYN_TRQ;
        op_stat[ASFE_OP_SYN_VEL] = state == ASFE_ST_SYN_VEL;
        op_stat[ASFE_OP_SYN_POS] = state == ASFE_ST_SYN_POS;
    end

    always_comb begin
        ctl_stat                  = 16'h0000;
        ctl_stat[ASFE_CS_ORG_DEF] = core.origin_defined;
        ctl_stat[ASFE_CS_AT_ORG]  = core.origin_defined &&
                                    core.in_position &&
                                    state == ASFE_ST_IDLE;
        ctl_stat[ASFE_CS_EVT_LSB +: ASFE_EVT_N] = evt_stat;
    end

    // axis command taken from the cyclic buffer per synchronous mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_src <= ASFE_SRC_NONE;
            axis_cmd <= 32'h0000_0000;
        end else begin
            case (state)
                ASFE_ST_SYN_TRQ: begin
                    axis_src <= ASFE_SRC_TRQ;
                    axis_cmd <= cyc_buf.torque;
                end
                ASFE_ST_SYN_VEL: begin
                    axis_src <= ASFE_SRC_VEL;
                    axis_cmd <= cyc_buf.speed;
                end
                ASFE_ST_SYN_POS: begin
                    axis_src <= ASFE_SRC_POS;
                    axis_cmd <= cyc_buf.position;
                end
                default: begin
                    axis_src <= ASFE_SRC_NONE;
                    axis_cmd <= 32'h0000_0000;
                end
            endcase
        end
    end

    // read data and error, answered in the access cycle
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (hit(idx, ASFE_IDX_CTRL)) begin
            prdata[ASFE_CTRL_LINEAR] = linear;
        end else if (hit(idx, ASFE_IDX_IRQ_STAT)) begin
            prdata[ASFE_EVT_N-1:0] = evt_stat;
        end else if (hit(idx, ASFE_IDX_IRQ_MASK)) begin
            prdata[ASFE_EVT_N-1:0] = evt_mask;
        end else if (hit(idx, ASFE_IDX_OP_STAT)) begin
            prdata[15:0] = op_stat;
        end else if (hit(idx, ASFE_IDX_CTL_STAT)) begin
            prdata[15:0] = ctl_stat;
        end else begin
            pslverr = psel && penable;
        end
        if (!rd_en) begin
            prdata = 32'h0000_0000;
        end
    end

endmodule // asfe_axis_status

// [dv/asfe_host_model.sv]
`timescale 1ns/10ps
module asfe_host_model
    import asfe_pkg::*;
(
    // apb master side
    input  wire logic                   pclk,
    input  wire logic [31:0]            prdata,
    input  wire logic                   pready,
    input  wire logic                   pslverr,
    output logic                        psel,
    output logic                        penable,
    output logic                        pwrite,
    output logic      [ASFE_ADDR_W+1:0] paddr,
    output logic      [31:0]            pwdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // holds the request until pready is seen; no latency is assumed
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // stale data would hide a slave that samples late
        pwdata  <= ~wd;
    endtask
endmodule // asfe_host_model

// [dv/asfe_axis_status_asserts.sv]
`timescale 1ns/10ps
module asfe_axis_status_asserts
    import asfe_pkg::*;
#(
    parameter int POS_W  = 32,
    parameter int STEP_W = 16
) (
    // apb
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [ASFE_ADDR_W+1:0]   paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     irq,
    // core and axis
    input wire asfe_core_t               core,
    input wire logic signed [STEP_W-1:0] cmd_step,
    input wire logic signed [STEP_W-1:0] fb_step,
    input wire asfe_cyc_buf_t            cyc_buf,
    input wire logic                     int_pin,
    input wire logic [1:0]               axis_src,
    input wire logic [31:0]              axis_cmd
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] idx;
    logic       acc;
    logic       rd_op;
    logic       rd_ctl;
    assign idx    = paddr[ASFE_ADDR_W+1:2];
    assign acc    = psel && penable;
    assign rd_op  = acc && !pwrite && idx == ASFE_IDX_OP_STAT;
    assign rd_ctl = acc && !pwrite && idx == ASFE_IDX_CTL_STAT;

    logic [1:0] lat_exp;
    // latch bits stay until a one is written to their status bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_exp <= 2'h0;
        end else if (acc && pwrite && idx == ASFE_IDX_IRQ_STAT) begin
            lat_exp <= (lat_exp & ~pwdata[1:0]) |
                       {core.origin_latch_done, core.latch_done};
        end else begin
            lat_exp <= lat_exp | {core.origin_latch_done, core.latch_done};
        end
    end

    chk_unused_zero: assert property (rd_op |-> !prdata[12] &&
        prdata[10:9] == 2'h0) else $error("unused op bits set");
    chk_mode_excl: assert property (rd_op |->
        $onehot0({prdata[15:13], prdata[11], prdata[8], prdata[6:4]}))
        else $error("two motion modes shown at once");
    chk_wait_mode: assert property (rd_op && prdata[7] |->
        prdata[6:4] != 3'h0) else $error("waiting without a move");
    chk_org_def: assert property (rd_ctl |->
        prdata[0] == core.origin_defined) else $error("origin bit wrong");
    chk_org_gate: assert property (rd_ctl && !core.origin_defined |->
        !prdata[1]) else $error("at origin without origin");
    chk_latch_seen: assert property (rd_ctl |->
        prdata[2] == lat_exp[0]) else $error("latch bit wrong");
    chk_olatch_seen: assert property (rd_ctl |->
        prdata[3] == lat_exp[1]) else $error("origin latch bit wrong");
    chk_trq_follow: assert property (axis_src == ASFE_SRC_TRQ |->
        axis_cmd == $past(cyc_buf.torque)) else $error("torque not followed");
    chk_vel_follow: assert property (axis_src == ASFE_SRC_VEL |->
        axis_cmd == $past(cyc_buf.speed)) else $error("speed not followed");
    chk_pos_follow: assert property (axis_src == ASFE_SRC_POS |->
        axis_cmd == $past(cyc_buf.position)) else $error("position lost");
endmodule // asfe_axis_status_asserts

bind asfe_axis_status asfe_axis_status_asserts #(
    .POS_W(POS_W), .STEP_W(STEP_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .core(core),
    .cmd_step(cmd_step), .fb_step(fb_step), .cyc_buf(cyc_buf),
    .int_pin(int_pin), .axis_src(axis_src), .axis_cmd(axis_cmd));

// [dv/tb.sv]
`timescale 1ns/10ps
module tb;
    import asfe_pkg::*;
    typedef struct packed {
        logic [2:0]  cmd;
        logic [15:0] op;
        logic [1:0]  src;
        logic        done;
    } asfe_row_t;

    logic                     pclk = 1'b0, presetn = 1'b0, int_pin = 1'b0;
    logic                     psel, penable, pwrite, pready, pslverr, irq;
    logic                     err;
    logic [ASFE_ADDR_W+1:0]   paddr;
    logic [31:0]              pwdata, prdata, axis_cmd, rdv;
    logic [1:0]               axis_src;
    logic signed [15:0]       cmd_step = '0, fb_step = '0;
    asfe_core_t               core = '0;
    asfe_cyc_buf_t            cyc_buf = {32'h1111_0001, 32'h2222_0002,
                                         32'h3333_0003};
    int                       fails = 0, compares = 0, cycles = 0;
    logic [2:0]               ifc [2] = '{ASFE_CMD_ABS, ASFE_CMD_SPEED};
    logic [15:0]              ife [2] = '{16'h0090, 16'h00c0};
    asfe_row_t                rows [7] = '{
        '{ASFE_CMD_ABS,     16'h0010, ASFE_SRC_NONE, 1'b1},
        '{ASFE_CMD_REL,     16'h0020, ASFE_SRC_NONE, 1'b1},
        '{ASFE_CMD_SPEED,   16'h0040, ASFE_SRC_NONE, 1'b0},
        '{ASFE_CMD_MEMORY,  16'h0800, ASFE_SRC_NONE, 1'b1},
        '{ASFE_CMD_SYN_TRQ, 16'h2000, ASFE_SRC_TRQ,  1'b0},
        '{ASFE_CMD_SYN_VEL, 16'h4000, ASFE_SRC_VEL,  1'b0},
        '{ASFE_CMD_SYN_POS, 16'h8000, ASFE_SRC_POS,  1'b0}};

    always #25 pclk = ~pclk;

    // a narrow position keeps wrap-around within a few cycles
    asfe_axis_status #(.POS_W(20), .STEP_W(16)) i_asfe_axis_status (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .core(core),
        .cmd_step(cmd_step), .fb_step(fb_step), .cyc_buf(cyc_buf),
        .int_pin(int_pin), .axis_src(axis_src), .axis_cmd(axis_cmd));

    asfe_host_model i_asfe_host_model (
        .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    task automatic conclude();
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        i_asfe_host_model.xfer(1'b1, idx, d, r, e);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx,
                         input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        i_asfe_host_model.xfer(1'b0, idx, 32'h0, r, e);
        check(what, r, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic pulse(input asfe_core_t m);
        core <= core | m;
        @(posedge pclk);
        core <= core & ~m;
    endtask

    task automatic steps(input logic signed [15:0] c, f, input int n);
        cmd_step <= c;
        fb_step <= f;
        idle(n);
        cmd_step <= '0;
        fb_step <= '0;
        idle(1);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        idle(5);
        presetn <= 1'b1;
        rdchk("ctrl_reset", ASFE_IDX_CTRL, 32'h100);
        rdchk("op_reset", ASFE_IDX_OP_STAT, 32'h0);
        rdchk("mask_reset", ASFE_IDX_IRQ_MASK, 32'h0);
        wr(ASFE_IDX_OP_STAT, 32'hffff);
        rdchk("op_readonly", ASFE_IDX_OP_STAT, 32'h0);
        i_asfe_host_model.xfer(1'b0, 8'h01, 32'h0, rdv, err);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rdv, 32'h0);
        foreach (rows[i]) begin
            wr(ASFE_IDX_CTRL, 32'h100 | 32'(rows[i].cmd));
            idle(1);
            rdchk("op_mode", ASFE_IDX_OP_STAT,
                  32'(rows[i].op));
            check("axis_src", 32'(axis_src),
                  32'(rows[i].src));
            rdv = (rows[i].src == ASFE_SRC_NONE) ? 32'h0 :
                  cyc_buf[(3 - rows[i].src) * 32 +: 32];
            check("axis_cmd", axis_cmd, rdv);
            if (rows[i].done) pulse(5'b10000);
            else wr(ASFE_IDX_CTRL, 32'h110);
            idle(1);
            rdchk("op_end", ASFE_IDX_OP_STAT, 32'h0);
        end
        for (int k = 0; k < 2; k++) begin
            wr(ASFE_IDX_CTRL, 32'h108 | 32'(ifc[k]));
            idle(1);
            rdchk("feed_wait", ASFE_IDX_OP_STAT, 32'(ife[k]));
            wr(ASFE_IDX_CTRL, 32'h102);
            idle(1);
            rdchk("busy_cmd", ASFE_IDX_OP_STAT, 32'(ife[k]));
            int_pin <= 1'b1;
            idle(6);
            rdchk("feed_pos", ASFE_IDX_OP_STAT, 32'h100);
            int_pin <= 1'b0;
            pulse(5'b10000);
            idle(4);
            rdchk("feed_end", ASFE_IDX_OP_STAT, 32'h0);
        end
        core <= 5'b01100;
        idle(1);
        rdchk("at_origin", ASFE_IDX_CTL_STAT, 32'h3);
        core <= 5'b01000;
        idle(1);
        rdchk("off_origin", ASFE_IDX_CTL_STAT, 32'h1);
        core <= 5'b00100;
        idle(1);
        rdchk("no_origin", ASFE_IDX_CTL_STAT, 32'h0);
        pulse(5'b00011);
        steps(16'sh7fff, -16'sh7fff, 20);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rdchk("events_a", ASFE_IDX_CTL_STAT, 32'h9c);
        wr(ASFE_IDX_IRQ_MASK, 32'h3f);
        idle(2);
        check("irq_set", {31'h0, irq}, 32'h1);
        wr(ASFE_IDX_IRQ_STAT, 32'h3f);
        idle(2);
        check("irq_clear", {31'h0, irq}, 32'h0);
        rdchk("cleared", ASFE_IDX_CTL_STAT, 32'h0);
        steps(-16'sh7fff, 16'sh7fff, 40);
        rdchk("events_b", ASFE_IDX_CTL_STAT, 32'h60);
        wr(ASFE_IDX_IRQ_STAT, 32'h3f);
        wr(ASFE_IDX_CTRL, 32'h0);
        steps(16'sh7fff, 16'sh7fff, 40);
        rdchk("wrap_mode", ASFE_IDX_CTL_STAT, 32'h0);
        // reset in the middle of a synchronous mode
        wr(ASFE_IDX_CTRL, 32'(ASFE_CMD_SYN_POS));
        idle(2);
        check("sync_cmd", axis_cmd, 32'h3333_0003);
        presetn <= 1'b0;
        idle(2);
        check("reset_src", 32'(axis_src), 32'h0);
        presetn <= 1'b1;
        rdchk("op_rerun", ASFE_IDX_OP_STAT, 32'h0);
        rdchk("ctrl_rerun", ASFE_IDX_CTRL, 32'h100);
        conclude();
    end
endmodule // tb
